// ### fifo_flags_pkg.sv
// Shared constants, types and helpers for the FIFO status-flag and output logic.
package fifo_flags_pkg;
   localparam int DEPTH = 512;
   localparam int AW = 9;
   localparam int CW = 11;
   localparam int DW = 72;
   localparam int LW = 18;
   localparam logic [CW-1:0] DEPTH_C = 11'h200;
   localparam logic [CW-1:0] HALF_C = 11'h100;
   localparam logic [CW-1:0] CNT_RST = 11'h000;
   localparam logic [AW-1:0] PTR_RST = 9'h000;
   localparam logic [AW-1:0] OFFSET_RST = 9'h07F;
   localparam logic [DW-1:0] DATA_RST = 72'h0;
   localparam logic [2:0] PIPE_RST = 3'h0;
   localparam logic [1:0] LANE_RST = 2'h0;

   typedef enum logic [1:0] {OUT_W72, OUT_W36, OUT_W18} out_width_t;

   // Index of the last narrow read that makes up one long word.
   function automatic logic [1:0] lane_last(input out_width_t w);
      case (w)
         OUT_W36: lane_last = 2'h1;
         OUT_W18: lane_last = 2'h3;
         default: lane_last = 2'h0;
      endcase
   endfunction
endpackage

// ### store_if.sv
// Connection between the flag controller and the word storage array.
`timescale 1ns/1ns
interface store_if;
   logic wr_en;
   logic [fifo_flags_pkg::AW-1:0] wr_addr;
   logic [fifo_flags_pkg::DW-1:0] wr_data;
   logic [fifo_flags_pkg::AW-1:0] rd_addr;
   logic [fifo_flags_pkg::DW-1:0] rd_data;
   modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ### fifo_store.sv
// Word storage array with clocked write and direct read.
`timescale 1ns/1ns
module fifo_store (
   input wire logic i_clk,
   store_if.mem port
);
   logic [fifo_flags_pkg::DW-1:0] mem_q [fifo_flags_pkg::DEPTH];

   // The array has no reset; the pointers keep stale words from being seen.
   always_ff @(posedge i_clk) begin
      if (port.wr_en) begin
         mem_q[port.wr_addr] <= port.wr_data;
      end
   end

   assign port.rd_data = mem_q[port.rd_addr];
endmodule

// ### lane_select.sv
// Picks the part of a long word shown on the outputs for one narrow read.
`timescale 1ns/1ns
module lane_select (
   input wire logic [fifo_flags_pkg::DW-1:0] i_word,
   input wire logic [1:0] i_lane,
   input wire fifo_flags_pkg::out_width_t i_width,
   input wire logic i_little,
   output logic [fifo_flags_pkg::DW-1:0] o_data
);
   logic [1:0] sel;

   always_comb begin
      sel = i_little ? 2'(fifo_flags_pkg::lane_last(i_width) - i_lane) : i_lane; // [RULE_20] [RULE_21]
      case (i_width)
         fifo_flags_pkg::OUT_W36: begin
            o_data = {36'h0, sel[0] ? i_word[35:0] : i_word[71:36]}; // [RULE_18] [RULE_20]
         end
         fifo_flags_pkg::OUT_W18: begin
            case (sel) // [RULE_21]
               2'h0: o_data = {54'h0, i_word[71:54]};
               2'h1: o_data = {54'h0, i_word[53:36]};
               2'h2: o_data = {54'h0, i_word[35:18]};
               default: o_data = {54'h0, i_word[17:0]};
            endcase
         end
         default: begin
            o_data = i_word; // [RULE_19]
         end
      endcase
   end
endmodule

// ### fifo_flags_top.sv
// Status flags, read sequencing and bus matching of a 72-bit FIFO.
//
// Behaviour
// RULE_01: Standard mode: empty flag low when nothing stored; reads blocked while low.
// RULE_02: Fall-through: ready flag goes low together with the first word on outputs.
// RULE_03: Fall-through: ready stays low after last word moves out; rises only on a read.
// RULE_04: After the final read the last word stays on outputs; reads ignored meanwhile.
// RULE_05: Empty/ready flag changes only on read-side clock edges.
// RULE_06: Empty flag lags by two stages, ready flag by three stages.
// RULE_07: Standard mode: almost-full low once depth minus full offset words stored.
// RULE_08: Fall-through: almost-full low one word later, depth plus one minus offset.
// RULE_09: Asynchronous timing: almost-full asserts on writes, releases on reads.
// RULE_10: Synchronous timing: almost-full updated on every write-side edge.
// RULE_11: Standard mode: almost-empty low while count is at most the empty offset.
// RULE_12: Fall-through: almost-empty low while count, output word included, is offset+1 or less.
// RULE_13: Asynchronous timing: almost-empty asserts on reads, releases on writes.
// RULE_14: Synchronous timing: almost-empty updated on every read-side edge.
// RULE_15: Half-full goes low on a write above half depth, high on a read back.
// RULE_16: Standard mode: half-full low after half depth plus one writes.
// RULE_17: Fall-through: half-full low after half depth plus two writes.
// RULE_18: Read data sits on the low 72, 36 or 18 output bits.
// RULE_19: Without bus matching the four 18-bit lanes keep their positions.
// RULE_20: 72 to 36: two reads per word, upper half first unless little-endian.
// RULE_21: 72 to 18: four reads per word, top lane first unless little-endian.
// RULE_22: Flag timing select is held steady by the user during master reset.
// RULE_23: Endian select is held steady by the user during master reset.
// RULE_24: Offsets are captured into registers at master reset and compared with counts.
`timescale 1ns/1ns
module fifo_flags_top (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_master_reset_n,
   input wire logic i_partial_reset_n,
   input wire logic i_write_en,
   input wire logic [71:0] i_write_data_in,
   input wire logic i_read_en,
   input wire logic i_fall_through_mode,
   input wire logic i_flag_timing_select,
   input wire logic i_endian_select,
   input wire logic i_bus_match_enable,
   input wire logic i_input_width_select,
   input wire logic i_output_width_select,
   input wire logic [8:0] i_full_offset,
   input wire logic [8:0] i_empty_offset,
   output logic [71:0] o_read_data_out,
   output logic o_empty_flag_n,
   output logic o_almost_full_flag_n,
   output logic o_almost_empty_flag_n,
   output logic o_half_full_flag_n
);
   localparam int CW = fifo_flags_pkg::CW;

   store_if store ();

   logic fall_through_mode_q;
   logic sync_q;
   logic little_q;
   fifo_flags_pkg::out_width_t width_q;
   logic [8:0] full_off_q;
   logic [8:0] empty_off_q;
   logic [8:0] wr_ptr_q;
   logic [8:0] rd_ptr_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic [2:0] pipe_q;
   logic [2:0] pipe_d;
   logic have_q;
   logic have_d;
   logic [1:0] lane_q;
   logic [1:0] lane_d;
   logic [71:0] hold_q;
   logic [71:0] word_d;
   logic [71:0] shown;
   logic clr;
   logic fall_through_mode_n;
   logic more;
   logic wr_ok;
   logic std_fire;
   logic fw_fire;
   logic adv;
   logic pop;
   logic drop;
   logic flag_d;
   logic [CW-1:0] total_d;
   logic [CW-1:0] total_now;
   logic [CW-1:0] cap;
   logic af_cond;
   logic ae_cond;
   logic hf_cond;

   fifo_store u_store (
      .i_clk(i_clk),
      .port(store.mem)
   );

   lane_select u_lane (
      .i_word(word_d),
      .i_lane(lane_d),
      .i_width(width_q),
      .i_little(little_q),
      .o_data(shown)
   );

   assign store.wr_en = wr_ok;
   assign store.wr_addr = wr_ptr_q;
   assign store.wr_data = i_write_data_in;
   assign store.rd_addr = rd_ptr_q;

   // Mode pins count only while master reset is held; later changes are ignored.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         fall_through_mode_q <= 1'b0;
         sync_q <= 1'b0;
         little_q <= 1'b0;
         width_q <= fifo_flags_pkg::OUT_W72;
         full_off_q <= fifo_flags_pkg::OFFSET_RST;
         empty_off_q <= fifo_flags_pkg::OFFSET_RST;
      end else if (!i_master_reset_n) begin
         fall_through_mode_q <= i_fall_through_mode;
         sync_q <= i_flag_timing_select; // [RULE_22]
         little_q <= i_endian_select; // [RULE_23]
         full_off_q <= i_full_offset; // [RULE_24]
         empty_off_q <= i_empty_offset; // [RULE_24]
         if (!i_bus_match_enable || i_input_width_select) begin
            width_q <= fifo_flags_pkg::OUT_W72;
         end else if (i_output_width_select) begin
            width_q <= fifo_flags_pkg::OUT_W18;
         end else begin
            width_q <= fifo_flags_pkg::OUT_W36;
         end
      end
   end

   always_comb begin
      clr = !i_master_reset_n || !i_partial_reset_n;
      fall_through_mode_n = !i_master_reset_n ? i_fall_through_mode : fall_through_mode_q;
      more = have_q && (lane_q != fifo_flags_pkg::lane_last(width_q));
      // Writes past a full array are dropped; full signalling lives elsewhere.
      wr_ok = i_write_en && (cnt_q != fifo_flags_pkg::DEPTH_C) && !clr;
      std_fire = !fall_through_mode_q && i_read_en && o_empty_flag_n && (more || (pipe_q[0] && pipe_q[1])); // [RULE_01]
      fw_fire = fall_through_mode_q && i_read_en && have_q; // [RULE_04]
      adv = (std_fire || fw_fire) && more && !clr;
      pop = !clr && !adv && (std_fire || (fall_through_mode_q && (fw_fire || !have_q) && (&pipe_q)));
      drop = fw_fire && !more && !pop; // [RULE_03] [RULE_04]
      cnt_d = clr ? fifo_flags_pkg::CNT_RST : CW'(cnt_q + CW'(wr_ok) - CW'(pop));
      have_d = clr ? 1'b0 : (pop ? 1'b1 : (drop ? 1'b0 : have_q));
      lane_d = (clr || pop) ? fifo_flags_pkg::LANE_RST : (adv ? 2'(lane_q + 2'h1) : lane_q);
      pipe_d = clr ? fifo_flags_pkg::PIPE_RST : {pipe_q[1:0], cnt_d != fifo_flags_pkg::CNT_RST}; // [RULE_06]
      word_d = pop ? store.rd_data : hold_q;
      if (fall_through_mode_n) begin
         flag_d = !have_d; // [RULE_02] [RULE_03]
      end else begin
         flag_d = (have_d && (lane_d != fifo_flags_pkg::lane_last(width_q))) || (pipe_d[0] && pipe_d[1]); // [RULE_06]
      end
      total_d = CW'(cnt_d + CW'(fall_through_mode_q && have_d)); // [RULE_12]
      total_now = CW'(cnt_q + CW'(fall_through_mode_q && have_q));
      cap = CW'(fifo_flags_pkg::DEPTH_C + CW'(fall_through_mode_q)); // [RULE_08]
      af_cond = CW'(total_d + CW'(full_off_q)) >= cap; // [RULE_07] [RULE_08]
      ae_cond = total_d <= CW'(CW'(empty_off_q) + CW'(fall_through_mode_q)); // [RULE_11] [RULE_12]
      hf_cond = total_d > CW'(fifo_flags_pkg::HALF_C + CW'(fall_through_mode_q)); // [RULE_16] [RULE_17]
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_ptr_q <= fifo_flags_pkg::PTR_RST;
         rd_ptr_q <= fifo_flags_pkg::PTR_RST;
         cnt_q <= fifo_flags_pkg::CNT_RST;
         pipe_q <= fifo_flags_pkg::PIPE_RST;
      end else begin
         cnt_q <= cnt_d;
         pipe_q <= pipe_d;
         if (clr) begin
            wr_ptr_q <= fifo_flags_pkg::PTR_RST;
            rd_ptr_q <= fifo_flags_pkg::PTR_RST;
         end else begin
            if (wr_ok) begin
               wr_ptr_q <= 9'(wr_ptr_q + 9'h001);
            end
            if (pop) begin
               rd_ptr_q <= 9'(rd_ptr_q + 9'h001);
            end
         end
      end
   end

   // Output register: apart from master or partial reset it changes only when a word or lane moves out, so the last word stays put.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         have_q <= 1'b0;
         lane_q <= fifo_flags_pkg::LANE_RST;
         hold_q <= fifo_flags_pkg::DATA_RST;
         o_read_data_out <= fifo_flags_pkg::DATA_RST;
      end else begin
         have_q <= have_d;
         lane_q <= lane_d;
         if (clr) begin
            hold_q <= fifo_flags_pkg::DATA_RST;
            o_read_data_out <= fifo_flags_pkg::DATA_RST;
         end else if (pop || adv) begin
            hold_q <= word_d;
            o_read_data_out <= shown; // [RULE_18] [RULE_04]
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_empty_flag_n <= 1'b0;
      end else begin
         o_empty_flag_n <= flag_d; // [RULE_05]
      end
   end

   // Asynchronous timing lets each side move a flag only in its own direction.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_almost_full_flag_n <= 1'b1;
      end else if (clr) begin
         o_almost_full_flag_n <= 1'b1;
      end else if (sync_q) begin
         o_almost_full_flag_n <= !af_cond; // [RULE_10]
      end else if (wr_ok && af_cond) begin
         o_almost_full_flag_n <= 1'b0; // [RULE_09]
      end else if (pop && !af_cond) begin
         o_almost_full_flag_n <= 1'b1; // [RULE_09]
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_almost_empty_flag_n <= 1'b0;
      end else if (clr) begin
         o_almost_empty_flag_n <= 1'b0;
      end else if (sync_q) begin
         o_almost_empty_flag_n <= !ae_cond; // [RULE_14]
      end else if (pop && ae_cond) begin
         o_almost_empty_flag_n <= 1'b0; // [RULE_13]
      end else if (wr_ok && !ae_cond) begin
         o_almost_empty_flag_n <= 1'b1; // [RULE_13]
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_half_full_flag_n <= 1'b1;
      end else if (clr) begin
         o_half_full_flag_n <= 1'b1;
      end else if (wr_ok && hf_cond) begin
         o_half_full_flag_n <= 1'b0; // [RULE_15]
      end else if (pop && !hf_cond) begin
         o_half_full_flag_n <= 1'b1; // [RULE_15]
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   sequence s_first_write;
      (!fall_through_mode_q && !clr && wr_ok && cnt_q == fifo_flags_pkg::CNT_RST && !have_q) ##1 !clr;
   endsequence

   a_empty_blocks_read: assert property (!fall_through_mode_q && !o_empty_flag_n && !clr |=> $stable(o_read_data_out)) // [RULE_01]
      else $error("read data moved while empty flag low");
   a_ready_with_data: assert property (fall_through_mode_q && $past(fall_through_mode_q) && $fell(o_empty_flag_n) |-> $past(pop)) // [RULE_02]
      else $error("output ready asserted without a word loaded");
   a_ready_rise_read: assert property (fall_through_mode_q && $past(fall_through_mode_q) && $rose(o_empty_flag_n)
      |-> $past(i_read_en) || $past(clr)) // [RULE_03]
      else $error("output ready released without a read");
   a_last_word_held: assert property (fall_through_mode_q && o_empty_flag_n && $past(o_empty_flag_n) && !$past(clr)
      |-> $stable(o_read_data_out)) // [RULE_04]
      else $error("last word not held after final read");
   a_empty_two_stage: assert property (s_first_write |-> !o_empty_flag_n ##1 o_empty_flag_n) // [RULE_06]
      else $error("empty flag latency is not two stages");
   a_af_sync_level: assert property (sync_q && $past(i_master_reset_n)
      |-> o_almost_full_flag_n == !(CW'(total_now + CW'(full_off_q)) >= cap)) // [RULE_07] [RULE_08]
      else $error("almost-full does not match fill level");
   a_ae_sync_level: assert property (sync_q && $past(i_master_reset_n)
      |-> o_almost_empty_flag_n == !(total_now <= CW'(CW'(empty_off_q) + CW'(fall_through_mode_q)))) // [RULE_11] [RULE_12]
      else $error("almost-empty does not match fill level");
   a_af_async_write: assert property (!sync_q && $fell(o_almost_full_flag_n) |-> $past(wr_ok)) // [RULE_09]
      else $error("async almost-full asserted without a write");
   a_ae_async_read: assert property (!sync_q && $fell(o_almost_empty_flag_n) && !$past(clr)
      |-> $past(pop)) // [RULE_13]
      else $error("async almost-empty asserted without a read");
   a_hf_level: assert property ($past(i_master_reset_n)
      |-> o_half_full_flag_n == !(total_now > CW'(fifo_flags_pkg::HALF_C + CW'(fall_through_mode_q)))) // [RULE_16] [RULE_17]
      else $error("half-full does not match fill level");
   a_hf_on_write: assert property ($fell(o_half_full_flag_n) |-> $past(wr_ok)) // [RULE_15]
      else $error("half-full asserted without a write");
   a_narrow_upper_zero: assert property (width_q == fifo_flags_pkg::OUT_W18 && $past(width_q) == width_q
      && $past(i_master_reset_n) |-> o_read_data_out[71:18] == 54'h0) // [RULE_18]
      else $error("upper output bits not zero in x18 mode");
endmodule

// ### stream_agent.sv
// Writer and reader model that drives the data side of the FIFO.
`timescale 1ns/1ns
module stream_agent (
   input wire logic i_clk,
   output logic o_write_en,
   output logic [71:0] o_write_data,
   output logic o_read_en
);
   initial begin
      o_write_en = 1'b0;
      o_write_data = 72'h0;
      o_read_en = 1'b0;
   end

   // Requests change on the falling edge so they are stable at the sampling edge.
   task automatic push(input logic [71:0] d);
      o_write_en = 1'b1;
      o_write_data = d;
      @(negedge i_clk);
   endtask

   task automatic pop();
      o_read_en = 1'b1;
      @(negedge i_clk);
   endtask

   // Idle data is inverted so a stale word can never pass for a fresh one.
   task automatic idle();
      o_write_en = 1'b0;
      o_read_en = 1'b0;
      o_write_data = ~o_write_data;
   endtask
endmodule

// ### tb_top.sv
// Self-checking testbench for the FIFO status flags and bus matching.
`timescale 1ns/1ns
module tb_top;
   logic clk, rst, mrst_n, prst_n, we, re, fall_through_mode, flag_timing_select, endian, bm, ow, iw;
   logic [71:0] wd, rdata, exp;
   logic [8:0] full_off, empty_off;
   logic ef_n, af_n, ae_n, hf_n;
   int mismatches, num_checks, n, h, w;

   stream_agent u_stream_agent (.i_clk(clk), .o_write_en(we), .o_write_data(wd), .o_read_en(re));

   fifo_flags_top u_fifo_flags_top (.i_clk(clk), .i_rst(rst), .i_master_reset_n(mrst_n),
      .i_partial_reset_n(prst_n), .i_write_en(we), .i_write_data_in(wd), .i_read_en(re),
      .i_fall_through_mode(fall_through_mode), .i_flag_timing_select(flag_timing_select), .i_endian_select(endian),
      .i_bus_match_enable(bm), .i_input_width_select(iw), .i_output_width_select(ow),
      .i_full_offset(full_off), .i_empty_offset(empty_off), .o_read_data_out(rdata),
      .o_empty_flag_n(ef_n), .o_almost_full_flag_n(af_n), .o_almost_empty_flag_n(ae_n),
      .o_half_full_flag_n(hf_n));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [71:0] pat(input int i);
      pat = {18'(i) ^ 18'h3A5C1, 18'(i) ^ 18'h24C3B, 18'(i) ^ 18'h1F00E, 18'(i) ^ 18'h0D2A7};
   endfunction

   task automatic check(input string name, input logic [71:0] e, input logic [71:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic chkf(input string name, input logic e, input logic g);
      check(name, {71'h0, e}, {71'h0, g});
   endtask

   task automatic flags(input logic af, input logic hf, input logic ae);
      chkf("almost_full", af, af_n);
      chkf("half_full", hf, hf_n);
      chkf("almost_empty", ae, ae_n);
   endtask

   // Mode pins stay where they were set after the reset ends.
   task automatic master(input logic f, input logic t, input logic b, input logic m, input logic o);
      fall_through_mode = f;
      flag_timing_select = t;
      endian = b;
      bm = m;
      ow = o;
      mrst_n = 1'b0;
      @(negedge clk);
      mrst_n = 1'b1;
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      #200000;
      mismatches++;
      finish_test();
   end

   initial begin
      rst = 1'b1;
      mrst_n = 1'b1;
      prst_n = 1'b1;
      {fall_through_mode, flag_timing_select, endian, bm, ow, iw} = 6'h00;
      full_off = 9'h004;
      empty_off = 9'h002;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      // Standard mode, synchronous flag timing, full width.
      master(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      chkf("empty", 1'b0, ef_n);
      flags(1'b1, 1'b1, 1'b0);
      u_stream_agent.pop();
      u_stream_agent.idle();
      check("data", 72'h0, rdata);
      @(negedge clk);
      u_stream_agent.push(pat(0));
      u_stream_agent.idle();
      chkf("empty", 1'b0, ef_n);
      @(negedge clk);
      chkf("empty", 1'b1, ef_n);
      for (int k = 1; k < 513; k++) begin
         u_stream_agent.push(pat(k));
         flags(!(k + 1 + 4 >= 512), !(k + 1 > 256), !(k + 1 <= 2));
      end
      // The last refused write must not stay requested while the array drains.
      u_stream_agent.idle();
      @(negedge clk);
      for (int k = 0; k < 512; k++) begin
         u_stream_agent.pop();
         check("data", pat(k), rdata);
         flags(!(511 - k + 4 >= 512), !(511 - k > 256), !(511 - k <= 2));
      end
      u_stream_agent.idle();
      chkf("empty", 1'b0, ef_n);
      @(negedge clk);
      u_stream_agent.pop();
      u_stream_agent.idle();
      check("data", pat(511), rdata);
      // Narrow outputs in both byte orders.
      for (int c = 0; c < 4; c++) begin
         master(1'b0, 1'b1, c[0], 1'b1, c[1]);
         u_stream_agent.push(pat(7 + c));
         u_stream_agent.idle();
         repeat (3) @(negedge clk);
         n = c[1] ? 4 : 2;
         w = c[1] ? 18 : 36;
         for (int j = 0; j < n; j++) begin
            u_stream_agent.pop();
            h = c[0] ? j : n - 1 - j;
            exp = (pat(7 + c) >> (w * h)) & ((72'h1 << w) - 72'h1);
            check("lane", exp, rdata);
         end
         u_stream_agent.idle();
      end
      // Fall-through mode with asynchronous flag timing.
      // Wide input select with bus matching on must still give full-width words.
      iw = 1'b1;
      master(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
      chkf("ready", 1'b1, ef_n);
      u_stream_agent.push(pat(1));
      u_stream_agent.idle();
      chkf("ready", 1'b1, ef_n);
      @(negedge clk);
      chkf("ready", 1'b1, ef_n);
      @(negedge clk);
      chkf("ready", 1'b1, ef_n);
      @(negedge clk);
      chkf("ready", 1'b0, ef_n);
      check("data", pat(1), rdata);
      for (int r = 0; r < 2; r++) begin
         u_stream_agent.pop();
         u_stream_agent.idle();
         chkf("ready", 1'b1, ef_n);
         check("data", pat(1), rdata);
         @(negedge clk);
      end
      for (int k = 1; k <= 509; k++) begin
         u_stream_agent.push(pat(100 + k));
         flags(!(k >= 509), !(k >= 258), !(k <= 3));
      end
      u_stream_agent.idle();
      @(negedge clk);
      u_stream_agent.pop();
      u_stream_agent.idle();
      check("data", pat(102), rdata);
      chkf("almost_full", 1'b1, af_n);
      prst_n = 1'b0;
      @(negedge clk);
      prst_n = 1'b1;
      chkf("ready", 1'b1, ef_n);
      flags(1'b1, 1'b1, 1'b0);
      finish_test();
   end
endmodule
